// file: io_port_defs.vh
/*
 * constants for the remote i/o port manager: command codes, field layout,
 * factory defaults and timing counts.
 * assumes a 10 mhz core clock; included by the port manager files.
 */
`ifndef IO_PORT_DEFS_VH
`define IO_PORT_DEFS_VH

`define CLK_PERIOD_NS 100
`define RESTORE_HOLD_MS 1000
`define RESTORE_HOLD_CYCLES ((`RESTORE_HOLD_MS * 1000000) / `CLK_PERIOD_NS)

`define NUM_DIN 12
`define NUM_ADC 4
`define NUM_DOUT 10
`define ADC_W 10
`define ADC_STEPS 1024
`define ADC_MAX 10'h3ff
`define DEF_THRESHOLD 10'h200
`define DEF_LOCAL_PORT 16'h1771

// command register addresses
`define ADDR_W 4
`define A_CMD 4'h0
`define A_DIN_EN 4'h1
`define A_DOUT_COND 4'h2
`define A_ADC_MODE 4'h3
`define A_THRESH 4'h4
`define A_RESTORE_EN 4'h5
`define A_SEL 4'h6
`define A_STATUS 4'h8
`define A_REPORT 4'h9
`define A_CONFIG 4'ha

// command codes written to the command register
`define CMD_STATE_REQ 8'h01
`define CMD_OUT_CTRL 8'h02
`define CMD_RUN 8'h03
`define CMD_SETTING 8'h04

// report entry kinds
`define RPT_DIN 2'h0
`define RPT_ADC 2'h1
`define RPT_DOUT 2'h2

`endif

// file: adc_decimal.v
/*
 * converts a 10-bit adc code into four bcd digits, 0000 to 1023.
 * assumes the code is held stable while the conversion is read.
 */
`timescale 1ns/1ps
`default_nettype none
`include "io_port_defs.vh"

module adc_decimal #(
  parameter integer WIDTH = `ADC_W
) (
  input wire [WIDTH-1:0] code,
  output reg [15:0] bcd
);
  integer i;
  reg [15:0] acc;

  // shift-add-3, purely combinational so the report path has no latency
  always @* begin
    acc = 16'h0000;
    for (i = WIDTH - 1; i >= 0; i = i - 1) begin
      if (acc[3:0] > 4'h4) acc[3:0] = acc[3:0] + 4'h3;
      if (acc[7:4] > 4'h4) acc[7:4] = acc[7:4] + 4'h3;
      if (acc[11:8] > 4'h4) acc[11:8] = acc[11:8] + 4'h3;
      if (acc[15:12] > 4'h4) acc[15:12] = acc[15:12] + 4'h3;
      acc = {acc[14:0], code[i]};
    end
    bcd = acc;
  end
endmodule // adc_decimal

`default_nettype wire

// file: io_port_manager.v
/*
 * remote i/o port manager: digital inputs, adc inputs reported as codes or
 * threshold compares, condition-gated digital outputs, run/setting interlock
 * and factory restore from a held switch.
 * assumes commands arrive from a socket front end over the plain register
 * port, one strobe per cycle; pin inputs are synchronous to core_clk.
 */
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "io_port_defs.vh"

// Operation
// - switch held about one second restores factory defaults, then reboots
// - after restore, network uses dynamic addressing and serves on port 6001
// - defaults: ports enabled, recovery on, linear adc, threshold 512, run
// - state request answers with every input, adc and output state
// - linear mode reports adc as four decimal digits 0000 to 1023
// - threshold mode reports on when value exceeds threshold
// - output entry carries on/off, condition assigned and standby flag
// - output without condition inverts on each control command
// - conditioned output goes on if condition holds, else off and standby
// - after output control, full state of all ports is sent back
// - twelve digital inputs, each with its own enable setting
// - configuration refused in run mode; host switches to setting first
// - disabled input reports disabled whatever its level
// - device acts as tcp server accepting the host connection
// - output commanded on while condition fails enters standby instead
module io_port_manager #(
  parameter integer NUM_DIN = `NUM_DIN,
  parameter integer NUM_ADC = `NUM_ADC,
  parameter integer NUM_DOUT = `NUM_DOUT,
  parameter integer RESTORE_HOLD = `RESTORE_HOLD_CYCLES
) (
  input wire core_clk,
  input wire nrst,
  input wire [`ADDR_W-1:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata,
  input wire [NUM_DIN-1:0] din,
  input wire [NUM_ADC*`ADC_W-1:0] adc_value,
  input wire [NUM_DOUT-1:0] cond_met,
  input wire restore_sw,
  output reg [NUM_DOUT-1:0] dout,
  output reg [NUM_DOUT-1:0] standby,
  output reg run_mode,
  output reg dhcp_mode,
  output reg tcp_server,
  output reg [15:0] local_port,
  output reg reboot,
  output reg report_valid,
  output reg report_busy,
  output reg cmd_refused
);
  localparam [2:0] S_IDLE = 3'b001;
  localparam [2:0] S_REPORT = 3'b010;
  localparam [2:0] S_RESTORE = 3'b100;
  localparam integer ENTRIES = NUM_DIN + NUM_ADC + NUM_DOUT;
  localparam integer HOLD_W = 32;

  reg [2:0] state;
  reg [NUM_DIN-1:0] din_en;
  reg [NUM_DOUT-1:0] dout_cond;
  reg [NUM_ADC-1:0] adc_mode;
  reg [`ADC_W-1:0] threshold;
  reg [NUM_DOUT-1:0] restore_en;
  reg [7:0] entry_idx;
  reg [7:0] out_sel;
  reg [HOLD_W-1:0] hold_cnt;
  reg [31:0] report_word;
  reg [NUM_DOUT-1:0] next_dout;
  reg [NUM_DOUT-1:0] next_standby;
  reg [`ADC_W-1:0] cur_adc;
  wire [15:0] cur_bcd;
  wire cfg_wr;
  wire idle;

  // one-hot decode of a port index into a mask
  function [NUM_DOUT-1:0] sel_mask;
    input [7:0] idx;
    integer k;
    begin
      sel_mask = {NUM_DOUT{1'b0}};
      for (k = 0; k < NUM_DOUT; k = k + 1)
        if (idx == k[7:0]) sel_mask[k] = 1'b1;
    end
  endfunction

  assign idle = (state == S_IDLE);
  assign cfg_wr = wr && (addr != `A_CMD) && (addr != `A_SEL);

  // adc selected for the entry being reported
  always @* begin : adc_pick
    integer j;
    j = 0;
    cur_adc = {`ADC_W{1'b0}};
    for (j = 0; j < NUM_ADC; j = j + 1)
      if (entry_idx == (NUM_DIN + j))
        cur_adc = adc_value[j*`ADC_W +: `ADC_W];
  end

  adc_decimal #(
    .WIDTH(`ADC_W)
  ) u_dec (
    .code(cur_adc),
    .bcd(cur_bcd)
  );

  // one report entry: kind, port number, payload
  always @* begin : entry_build
    integer j;
    j = 0;
    report_word = 32'h00000000;
    if (entry_idx < NUM_DIN) begin
      report_word[31:30] = `RPT_DIN;
      report_word[23:16] = entry_idx;
      for (j = 0; j < NUM_DIN; j = j + 1)
        if (entry_idx == j[7:0]) begin
          report_word[1] = ~din_en[j];
          report_word[0] = din_en[j] & din[j];
        end
    end else if (entry_idx < NUM_DIN + NUM_ADC) begin
      report_word[31:30] = `RPT_ADC;
      report_word[23:16] = entry_idx - NUM_DIN[7:0];
      for (j = 0; j < NUM_ADC; j = j + 1)
        if (entry_idx == (NUM_DIN + j)) begin
          // mode flag shares the index byte, so it is raised only in compare mode
          if (adc_mode[j]) begin
            report_word[17] = 1'b1;
            report_word[0] = (cur_adc > threshold);
          end else
            report_word[15:0] = cur_bcd;
        end
    end else begin
      report_word[31:30] = `RPT_DOUT;
      report_word[23:16] = entry_idx - NUM_DIN[7:0] - NUM_ADC[7:0];
      for (j = 0; j < NUM_DOUT; j = j + 1)
        if (entry_idx == (NUM_DIN + NUM_ADC + j)) begin
          report_word[0] = dout[j];
          report_word[1] = dout_cond[j];
          report_word[2] = standby[j];
        end
    end
  end

  // output control: toggle, or follow the condition and park in standby
  always @* begin : out_ctrl
    integer j;
    j = 0;
    next_dout = dout;
    next_standby = standby;
    for (j = 0; j < NUM_DOUT; j = j + 1)
      if (out_sel == j[7:0]) begin
        if (!dout_cond[j]) begin
          next_dout[j] = ~dout[j];
          next_standby[j] = 1'b0;
        end else if (cond_met[j]) begin
          next_dout[j] = 1'b1;
          next_standby[j] = 1'b0;
        end else begin
          next_dout[j] = 1'b0;
          next_standby[j] = 1'b1;
        end
      end
  end

  always @(posedge core_clk) begin
    if (!nrst) begin
      state <= S_IDLE;
      din_en <= {NUM_DIN{1'b1}};
      dout_cond <= {NUM_DOUT{1'b0}};
      adc_mode <= {NUM_ADC{1'b0}};
      threshold <= `DEF_THRESHOLD;
      restore_en <= {NUM_DOUT{1'b1}};
      run_mode <= 1'b1;
      dhcp_mode <= 1'b1;
      tcp_server <= 1'b1;
      local_port <= `DEF_LOCAL_PORT;
      entry_idx <= 8'h00;
      out_sel <= 8'h00;
      hold_cnt <= {HOLD_W{1'b0}};
      dout <= {NUM_DOUT{1'b0}};
      standby <= {NUM_DOUT{1'b0}};
      reboot <= 1'b0;
      report_valid <= 1'b0;
      report_busy <= 1'b0;
      cmd_refused <= 1'b0;
      rdata <= 32'h00000000;
    end else begin
      report_valid <= 1'b0;
      cmd_refused <= 1'b0;
      reboot <= 1'b0;
      // switch must be held continuously; a release restarts the count
      if (!restore_sw)
        hold_cnt <= {HOLD_W{1'b0}};
      else if (hold_cnt < RESTORE_HOLD)
        hold_cnt <= hold_cnt + 1'b1;
      case (state)
        S_IDLE: begin
          if (restore_sw && hold_cnt == RESTORE_HOLD - 1) begin
            state <= S_RESTORE;
          end else if (wr && addr == `A_SEL) begin
            out_sel <= wdata[7:0];
          end else if (wr && addr == `A_CMD) begin
            case (wdata[7:0])
              `CMD_STATE_REQ: begin
                state <= S_REPORT;
                entry_idx <= 8'h00;
                report_busy <= 1'b1;
              end
              `CMD_OUT_CTRL: begin
                dout <= next_dout & sel_mask(out_sel) | dout & ~sel_mask(out_sel);
                standby <= next_standby;
                state <= S_REPORT;
                entry_idx <= 8'h00;
                report_busy <= 1'b1;
              end
              `CMD_RUN: run_mode <= 1'b1;
              `CMD_SETTING: run_mode <= 1'b0;
              default: cmd_refused <= 1'b1;
            endcase
          end else if (cfg_wr && run_mode) begin
            cmd_refused <= 1'b1;
          end else if (cfg_wr) begin
            case (addr)
              `A_DIN_EN: din_en <= wdata[NUM_DIN-1:0];
              `A_DOUT_COND: dout_cond <= wdata[NUM_DOUT-1:0];
              `A_ADC_MODE: adc_mode <= wdata[NUM_ADC-1:0];
              `A_THRESH: threshold <= wdata[`ADC_W-1:0];
              `A_RESTORE_EN: restore_en <= wdata[NUM_DOUT-1:0];
              default: cmd_refused <= 1'b1;
            endcase
          end
        end
        S_REPORT: begin
          // one entry per read of the report register; writes are refused
          if (wr) cmd_refused <= 1'b1;
          if (rd && addr == `A_REPORT) begin
            report_valid <= 1'b1;
            if (entry_idx == ENTRIES - 1) begin
              state <= S_IDLE;
              report_busy <= 1'b0;
              entry_idx <= 8'h00;
            end else begin
              entry_idx <= entry_idx + 8'h01;
            end
          end
        end
        S_RESTORE: begin
          din_en <= {NUM_DIN{1'b1}};
          dout_cond <= {NUM_DOUT{1'b0}};
          adc_mode <= {NUM_ADC{1'b0}};
          threshold <= `DEF_THRESHOLD;
          restore_en <= {NUM_DOUT{1'b1}};
          run_mode <= 1'b1;
          dhcp_mode <= 1'b1;
          tcp_server <= 1'b1;
          local_port <= `DEF_LOCAL_PORT;
          // reboot: outputs with recovery disabled drop to off
          dout <= dout & restore_en;
          standby <= {NUM_DOUT{1'b0}};
          report_busy <= 1'b0;
          reboot <= 1'b1;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
      if (rd) begin
        case (addr)
          `A_STATUS: rdata <= {26'h0, report_busy, run_mode, tcp_server,
                               dhcp_mode, state[2], state[1]};
          `A_REPORT: rdata <= report_busy ? report_word : 32'h00000000;
          `A_DIN_EN: rdata <= {{(32-NUM_DIN){1'b0}}, din_en};
          `A_DOUT_COND: rdata <= {{(32-NUM_DOUT){1'b0}}, dout_cond};
          `A_ADC_MODE: rdata <= {{(32-NUM_ADC){1'b0}}, adc_mode};
          `A_THRESH: rdata <= {{(32-`ADC_W){1'b0}}, threshold};
          `A_RESTORE_EN: rdata <= {{(32-NUM_DOUT){1'b0}}, restore_en};
          `A_SEL: rdata <= {24'h0, out_sel};
          `A_CONFIG: rdata <= {16'h0, local_port};
          default: rdata <= 32'h00000000;
        endcase
      end else begin
        rdata <= 32'h00000000;
      end
    end
  end
endmodule // io_port_manager

`default_nettype wire

// file: port_rules_chk.sv
/*
 * timing checks on the port manager's register port, report and outputs.
 * assumes it is bound to the manager and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none
module port_rules_chk #(
  parameter integer RESTORE_HOLD = 20
) (
  input wire core_clk,
  input wire nrst,
  input wire [3:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  input wire [31:0] rdata,
  input wire restore_sw,
  input wire [9:0] dout,
  input wire [9:0] standby,
  input wire run_mode,
  input wire reboot,
  input wire report_valid,
  input wire report_busy,
  input wire cmd_refused
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  integer hold_cnt;
  // counts consecutive cycles the switch is held; a release starts over
  always @(posedge core_clk) begin
    hold_cnt <= (!nrst || !restore_sw) ? 0 : hold_cnt + 1;
  end
  sequence s_req;
    wr && addr == 4'h0 && wdata[7:0] == 8'h01 && !report_busy;
  endsequence
  sequence s_cfg;
    wr && addr >= 4'h1 && addr <= 4'h5 && run_mode && !report_busy;
  endsequence
  sequence s_boot;
    run_mode && !report_busy ##1 !reboot;
  endsequence
  req_busy_a: assert property (s_req |=> report_busy)
    else $error("state request did not start a report");
  cfg_refuse_a: assert property (s_cfg |=> cmd_refused)
    else $error("config write taken in run mode");
  busy_refuse_a: assert property (wr && report_busy |=> cmd_refused)
    else $error("write taken during a report");
  valid_rd_a: assert property (report_valid |-> $past(rd) && $past(addr) == 4'h9)
    else $error("report valid without a report read");
  rdata_idle_a: assert property (!rd |=> rdata == 32'h0)
    else $error("read data outside the read answer cycle");
  hold_boot_a: assert property (reboot |-> hold_cnt >= RESTORE_HOLD)
    else $error("restart before the switch was held long enough");
  boot_defs_a: assert property (reboot |-> s_boot)
    else $error("restart pulse wrong or not in run state");
  on_standby_a: assert property ((dout & standby) == 10'h0)
    else $error("output on while in standby");
  dout_cause_a: assert property (!$stable(dout) |-> $past(wr) && $past(addr) == 4'h0 || reboot)
    else $error("output changed without a command");
endmodule // port_rules_chk
`default_nettype wire

// file: host_model.sv
/*
 * host side of the command port: one write or read at a time.
 * assumes a free running core_clk and a slave that never waits.
 */
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic core_clk,
  input wire logic [31:0] rdata,
  output logic [3:0] addr,
  output logic [31:0] wdata,
  output logic wr,
  output logic rd
);
  initial begin
    addr = 4'h0;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
  end
  // released lines show the inverse so stale values cannot pass
  task automatic put(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask
  // blocks until the answer, so one request is outstanding
  task automatic get(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    addr <= ~a;
    @(posedge core_clk);
    d = rdata;
  endtask
endmodule // host_model
`default_nettype wire

// file: test_remote_io_port_manager.sv
/*
 * self-checking bench: commands, report drain, output control, restore.
 * assumes io_port_manager, host_model and port_rules_chk are compiled.
 */
`timescale 1ns/1ps
`default_nettype none
module test_remote_io_port_manager;
  logic core_clk = 1'b0, nrst = 1'b0, restore_sw = 1'b0, seen;
  logic [11:0] din = 12'h0, m_en;
  logic [39:0] adc_value = 40'h0;
  logic [9:0] cond_met = 10'h0, m_cnd, m_on, m_sb, m_thr;
  logic [3:0] m_mode;
  logic [31:0] q;
  wire [3:0] addr;
  wire [31:0] wdata, rdata;
  wire [9:0] dout, standby;
  wire [15:0] local_port;
  wire wr, rd, run_mode, dhcp_mode, tcp_server, reboot, report_valid, report_busy, cmd_refused;
  integer fails = 0, check_count = 0, i, junk;
  always #50 core_clk = ~core_clk;
  io_port_manager #(.RESTORE_HOLD(20)) DUT (.core_clk(core_clk), .nrst(nrst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .din(din), .adc_value(adc_value),
    .cond_met(cond_met), .restore_sw(restore_sw), .dout(dout), .standby(standby),
    .run_mode(run_mode), .dhcp_mode(dhcp_mode), .tcp_server(tcp_server),
    .local_port(local_port), .reboot(reboot), .report_valid(report_valid),
    .report_busy(report_busy), .cmd_refused(cmd_refused));
  host_model host (.core_clk(core_clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd));
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] dec4(input logic [9:0] v);
    return {4'(v / 10'h3e8), 4'(v / 7'h64 % 4'ha), 4'(v / 4'ha % 4'ha), 4'(v % 4'ha)};
  endfunction
  task automatic defaults;
    m_en = 12'hfff;
    m_cnd = 10'h0;
    m_mode = 4'h0;
    m_thr = 10'h200;
  endtask
  task automatic report;
    logic [31:0] e;
    logic [9:0] v;
    for (i = 0; i < 26; i++) begin
      if (i < 12) e = {8'h00, 8'(i), 14'h0, !m_en[i], m_en[i] & din[i]};
      else if (i < 16) begin
        v = adc_value[(i - 12) * 10 +: 10];
        // threshold flag shares the index byte
        e = m_mode[i - 12] ? {8'h40, 8'(i - 12) | 8'h02, 15'h0, v > m_thr}
          : {8'h40, 8'(i - 12), dec4(v)};
      end else e = {8'h80, 8'(i - 16), 13'h0, m_sb[i - 16], m_cnd[i - 16], m_on[i - 16]};
      host.get(4'h9, q);
      chk(q, e);
      chk(report_valid, 1'b1);
    end
    chk(report_busy, 1'b0);
    chk({standby, dout}, {m_sb, m_on});
  endtask
  task automatic request(input logic [39:0] a);
    @(posedge core_clk);
    din <= 12'($urandom);
    adc_value <= a;
    host.put(4'h0, 32'h1);
    #1 chk(report_busy, 1'b1);
    report();
  endtask
  task automatic ctrl(input integer p, input logic c);
    @(posedge core_clk);
    cond_met <= {10{c}};
    host.put(4'h6, 32'(p));
    host.put(4'h0, 32'h2);
    if (!m_cnd[p]) {m_on[p], m_sb[p]} = {!m_on[p], 1'b0};
    else {m_on[p], m_sb[p]} = {c, !c};
    report();
  endtask
  initial begin
    #2_000_000;
    fails++;
    end_of_test();
  end
  initial begin
    junk = $urandom(59138);
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    defaults();
    {m_on, m_sb} = 20'h0;
    request(40'({$urandom, $urandom}));
    host.put(4'h1, 32'h0);
    #1 chk(cmd_refused, 1'b1);
    host.put(4'h0, 32'h1);
    host.put(4'h6, 32'h0);
    #1 chk(cmd_refused, 1'b1);
    report();
    host.put(4'h0, 32'h4);
    #1 chk(run_mode, 1'b0);
    m_en = 12'($urandom);
    host.put(4'h1, 32'(m_en));
    m_cnd = 10'h003;
    host.put(4'h2, 32'h3);
    m_mode = 4'ha;
    host.put(4'h3, 32'ha);
    host.put(4'h5, 32'h3fe);
    host.put(4'h4, 32'h200);
    #1 chk(cmd_refused, 1'b0);
    host.put(4'h0, 32'h3);
    #1 chk(run_mode, 1'b1);
    request({10'h201, 10'h3ff, 10'h200, 10'h000});
    ctrl(2, 1'b0);
    ctrl(2, 1'b1);
    ctrl(0, 1'b0);
    ctrl(1, 1'b1);
    ctrl(0, 1'b1);
    host.get(4'hf, q);
    chk(q, 32'h0);
    host.put(4'hf, 32'h0);
    #1 chk(cmd_refused, 1'b1);
    host.put(4'h0, 32'h7);
    #1 chk(cmd_refused, 1'b1);
    seen = 1'b0;
    @(posedge core_clk);
    restore_sw <= 1'b1;
    repeat (40) begin
      @(posedge core_clk);
      #1 if (reboot === 1'b1) seen = 1'b1;
    end
    @(posedge core_clk);
    restore_sw <= 1'b0;
    chk(seen, 1'b1);
    chk({dhcp_mode, tcp_server, run_mode, local_port}, {3'h7, 16'h1771});
    // port 0 had recovery off, so the restart dropped it
    m_on = m_on & 10'h3fe;
    defaults();
    request(40'({$urandom, $urandom}));
    end_of_test();
  end
endmodule // test_remote_io_port_manager
bind io_port_manager port_rules_chk #(.RESTORE_HOLD(RESTORE_HOLD)) chk_i (.core_clk(core_clk),
  .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .restore_sw(restore_sw), .dout(dout), .standby(standby), .run_mode(run_mode),
  .reboot(reboot), .report_valid(report_valid), .report_busy(report_busy),
  .cmd_refused(cmd_refused));
`default_nettype wire
